// ===== core/bptc_pkg.sv
/*
 bulk paper tray controller: shared constants, types and cable layout.
 assumes one 100 MHz clock shared by both ends and a synchronous reset.
*/
package bptc_pkg;
   localparam int FEED_TIME_MS = 200;
   localparam int CLK_MHZ = 100;
   localparam int FEED_CYCLES = FEED_TIME_MS * 1000 * CLK_MHZ;

   // status word carried from tray to engine board
   localparam int ST_PRESENT = 0;
   localparam int ST_EMPTY = 1;
   localparam int ST_AT_TOP = 2;
   localparam int ST_AT_BOTTOM = 3;
   localparam int ST_DOOR_OPEN = 4;
   localparam int ST_FEEDING = 5;
   localparam int ST_W = 6;

   // engine board error codes, bcd
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_EMPTY = 16'h0703;
   localparam logic [15:0] ERR_ABSENT = 16'h0707;
   localparam logic [15:0] ERR_PREREG = 16'h0823;
   localparam logic [15:0] ERR_BYP_TRAIL = 16'h0830;
   localparam logic [15:0] ERR_SHINGLE = 16'h0833;
   localparam logic [15:0] ERR_FUSER_BYP = 16'h1020;
   localparam logic [15:0] ERR_FUSER_TRAY = 16'h1023;

   // jam reports into the engine board
   localparam int JAM_PREREG = 0;
   localparam int JAM_BYP_TRAIL = 1;
   localparam int JAM_SHINGLE = 2;
   localparam int JAM_FUSER = 3;
   localparam int JAM_W = 4;

   // axi-lite register offsets of the engine board
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_ERROR = 4'h8;
   localparam logic [3:0] REG_IRQ_STAT = 4'hc;
   localparam logic [3:0] REG_IRQ_MASK = 4'h0 + 4'h0;
   localparam logic [4:0] REG_IRQ_MASK_A = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ctrl bits
   localparam int CTL_FEED = 0;
   localparam int CTL_SRC_TRAY = 1;

   // irq bits
   localparam int IRQ_ERROR = 0;
   localparam int IRQ_CLEARED = 1;
   localparam int IRQ_FEED_DONE = 2;
   localparam int IRQ_W = 3;

   typedef enum logic [3:0] {
      BPTC_IDLE = 4'b0001,
      BPTC_UP = 4'b0010,
      BPTC_DOWN = 4'b0100,
      BPTC_HOLD = 4'b1000
   } bptc_elev_t;
endpackage : bptc_pkg

// ===== core/bptc_cable_if.sv
/*
 interconnect cable between tray controller and engine board.
 assumes both ends share aclk; no pins are two-way.
*/
`timescale 1ns/1ns
interface bptc_cable_if;
   logic tray_present;
   logic [bptc_pkg::ST_W-1:0] status;
   logic feed_req;
   logic feed_done;
   modport tray (output tray_present, output status, output feed_done,
      input feed_req);
   modport engine (input tray_present, input status, input feed_done,
      output feed_req);
endinterface : bptc_cable_if

// ===== core/bptc_tray.sv
/*
 tray end: elevator motor, feed motor and status toward the cable.
 assumes switch inputs are synchronous and already debounced.
*/
`timescale 1ns/1ns
module bptc_tray #(
   parameter int FEED_CYCLES = bptc_pkg::FEED_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   bptc_cable_if.tray cable,
   input wire logic upper_sw_closed,
   input wire logic lower_sw_closed,
   input wire logic door_sw_closed,
   input wire logic paper_out,
   input wire logic lower_key,
   output logic motor_up,
   output logic motor_down,
   output logic feed_motor
);
   typedef struct packed {
      bptc_pkg::bptc_elev_t st;
      logic door_closed;
      logic key;
      logic [31:0] feed_cnt;
      logic feed_on;
      logic done;
      logic [bptc_pkg::ST_W-1:0] status;
   } bptc_tray_state_t;

   bptc_tray_state_t s_ff, nxt_s;
   logic at_top, at_bot, door_closed;

   assign at_top = upper_sw_closed;
   assign at_bot = lower_sw_closed;
   assign door_closed = door_sw_closed;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.door_closed = door_closed;
      nxt_s.key = lower_key;
      nxt_s.done = 1'b0;
      case (s_ff.st)
         bptc_pkg::BPTC_IDLE: begin
            if (!door_closed) begin
               nxt_s.st = bptc_pkg::BPTC_HOLD;
            end else if (paper_out && !at_bot) begin
               nxt_s.st = bptc_pkg::BPTC_DOWN;
            end else if (lower_key && !s_ff.key && !at_bot) begin
               nxt_s.st = bptc_pkg::BPTC_DOWN;
            end else if (!at_top && !paper_out && !lower_key) begin
               nxt_s.st = bptc_pkg::BPTC_HOLD;
            end
         end
         bptc_pkg::BPTC_UP: begin
            if (!door_closed) begin
               nxt_s.st = bptc_pkg::BPTC_HOLD;
            end else if (paper_out) begin
               nxt_s.st = at_bot ? bptc_pkg::BPTC_HOLD
                                 : bptc_pkg::BPTC_DOWN;
            end else if (lower_key && !s_ff.key) begin
               nxt_s.st = bptc_pkg::BPTC_DOWN;
            end else if (at_top) begin
               nxt_s.st = bptc_pkg::BPTC_HOLD;
            end
         end
         bptc_pkg::BPTC_DOWN: begin
            if (!door_closed || at_bot) begin
               nxt_s.st = bptc_pkg::BPTC_HOLD;
            end
         end
         bptc_pkg::BPTC_HOLD: begin
            // parked; an empty tray never rises on a door close
            if (door_closed && paper_out) begin
               if (!at_bot) begin
                  nxt_s.st = bptc_pkg::BPTC_DOWN;
               end
            end else if (door_closed && !s_ff.door_closed && !at_top) begin
               nxt_s.st = bptc_pkg::BPTC_UP;
            end else if (door_closed && lower_key && !s_ff.key &&
                         !at_bot) begin
               nxt_s.st = bptc_pkg::BPTC_DOWN;
            end
         end
         default: nxt_s.st = bptc_pkg::BPTC_HOLD;
      endcase
      if (s_ff.feed_on) begin
         if (s_ff.feed_cnt == 32'h0000_0001) begin
            nxt_s.feed_on = 1'b0;
            nxt_s.done = 1'b1;
         end
         nxt_s.feed_cnt = s_ff.feed_cnt - 32'h0000_0001;
      end else if (cable.feed_req && !paper_out && door_closed) begin
         nxt_s.feed_on = 1'b1;
         nxt_s.feed_cnt = 32'(FEED_CYCLES);
      end
      nxt_s.status = '0;
      nxt_s.status[bptc_pkg::ST_PRESENT] = 1'b1;
      nxt_s.status[bptc_pkg::ST_EMPTY] = paper_out;
      nxt_s.status[bptc_pkg::ST_AT_TOP] = at_top;
      nxt_s.status[bptc_pkg::ST_AT_BOTTOM] = at_bot;
      nxt_s.status[bptc_pkg::ST_DOOR_OPEN] = !door_closed;
      nxt_s.status[bptc_pkg::ST_FEEDING] = nxt_s.feed_on;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
         s_ff.st <= bptc_pkg::BPTC_UP;
         s_ff.door_closed <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // elevator motor outputs gated by live limits and door
   assign motor_up = (s_ff.st == bptc_pkg::BPTC_UP) && !at_top &&
      door_closed;
   assign motor_down = (s_ff.st == bptc_pkg::BPTC_DOWN) && !at_bot &&
      door_closed;
   assign feed_motor = s_ff.feed_on;
   assign cable.tray_present = 1'b1;
   assign cable.status = s_ff.status;
   assign cable.feed_done = s_ff.done;
endmodule : bptc_tray

// ===== core/bptc_engine.sv
/*
 engine board end: axi4-lite registers, error codes and print halt.
 assumes the tray end is joined through bptc_cable_if on the same aclk.
*/
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module bptc_engine (
   input wire logic aclk,
   input wire logic aresetn,
   bptc_cable_if.engine cable,
   input wire logic [bptc_pkg::JAM_W-1:0] jam,
   output logic print_halt,
   output logic irq,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      logic [15:0] err;
      logic [bptc_pkg::ST_W:0] snap;
      logic [1:0] ctrl;
      logic [bptc_pkg::IRQ_W-1:0] ist;
      logic [bptc_pkg::IRQ_W-1:0] imask;
      logic aw_got;
      logic w_got;
      logic [4:0] awaddr;
      logic [31:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bptc_eng_state_t;

   bptc_eng_state_t s_ff, nxt_s;
   logic [bptc_pkg::ST_W:0] inputs;
   logic [15:0] code;
   logic do_wr, do_rd;
   logic [bptc_pkg::IRQ_W-1:0] ev;

   function automatic logic [15:0] bptc_decode(
      input logic present, input logic empty,
      input logic [bptc_pkg::JAM_W-1:0] j, input logic tray_src);
      logic [15:0] c;
      c = bptc_pkg::ERR_NONE;
      if (!present) c = bptc_pkg::ERR_ABSENT;
      else if (j[bptc_pkg::JAM_FUSER])
         c = tray_src ? bptc_pkg::ERR_FUSER_TRAY
                      : bptc_pkg::ERR_FUSER_BYP;
      else if (j[bptc_pkg::JAM_PREREG]) c = bptc_pkg::ERR_PREREG;
      else if (j[bptc_pkg::JAM_BYP_TRAIL]) c = bptc_pkg::ERR_BYP_TRAIL;
      else if (j[bptc_pkg::JAM_SHINGLE]) c = bptc_pkg::ERR_SHINGLE;
      else if (empty) c = bptc_pkg::ERR_EMPTY;
      return c;
   endfunction : bptc_decode

   assign inputs = {cable.status, cable.tray_present};
   assign code = bptc_decode(cable.tray_present,
      cable.status[bptc_pkg::ST_EMPTY], jam,
      s_ff.ctrl[bptc_pkg::CTL_SRC_TRAY]);
   assign do_wr = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
   assign do_rd = s_axi_arvalid && !s_ff.rvalid;

   always_comb begin
      nxt_s = s_ff;
      ev = '0;
      nxt_s.snap = inputs;
      // latch first error; clear only when any status word bit (feeding included) or tray_present changes
      if (s_ff.err == bptc_pkg::ERR_NONE) begin
         if (code != bptc_pkg::ERR_NONE) begin
            nxt_s.err = code;
            ev[bptc_pkg::IRQ_ERROR] = 1'b1;
         end
      end else if (inputs != s_ff.snap) begin
         nxt_s.err = bptc_pkg::ERR_NONE;
         ev[bptc_pkg::IRQ_CLEARED] = 1'b1;
      end
      ev[bptc_pkg::IRQ_FEED_DONE] = cable.feed_done;
      nxt_s.ctrl[bptc_pkg::CTL_FEED] = 1'b0;
      if (s_axi_awvalid && !s_ff.aw_got) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_ff.w_got) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdata = s_axi_wdata;
      end
      if (do_wr) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = bptc_pkg::RESP_OKAY;
         case (s_ff.awaddr)
            {1'b0, bptc_pkg::REG_CTRL}:
               nxt_s.ctrl = s_ff.wdata[1:0];
            bptc_pkg::REG_IRQ_MASK_A:
               nxt_s.imask = s_ff.wdata[bptc_pkg::IRQ_W-1:0];
            {1'b0, bptc_pkg::REG_STATUS}, {1'b0, bptc_pkg::REG_ERROR},
            {1'b0, bptc_pkg::REG_IRQ_STAT}: ;
            default: nxt_s.bresp = bptc_pkg::RESP_SLVERR;
         endcase
      end
      if (s_ff.bvalid && s_axi_bready) nxt_s.bvalid = 1'b0;
      nxt_s.ist = s_ff.ist;
      if (do_rd) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = bptc_pkg::RESP_OKAY;
         nxt_s.rdata = '0;
         case (s_axi_araddr)
            {1'b0, bptc_pkg::REG_CTRL}: nxt_s.rdata[1:0] = s_ff.ctrl;
            {1'b0, bptc_pkg::REG_STATUS}:
               nxt_s.rdata[bptc_pkg::ST_W:0] = inputs;
            {1'b0, bptc_pkg::REG_ERROR}: nxt_s.rdata[15:0] = s_ff.err;
            {1'b0, bptc_pkg::REG_IRQ_STAT}: begin
               nxt_s.rdata[bptc_pkg::IRQ_W-1:0] = s_ff.ist;
               nxt_s.ist = '0;
            end
            bptc_pkg::REG_IRQ_MASK_A:
               nxt_s.rdata[bptc_pkg::IRQ_W-1:0] = s_ff.imask;
            default: nxt_s.rresp = bptc_pkg::RESP_SLVERR;
         endcase
      end
      if (s_ff.rvalid && s_axi_rready) nxt_s.rvalid = 1'b0;
      nxt_s.ist = nxt_s.ist | ev; // set wins over read clear
      if (do_wr && s_ff.awaddr == {1'b0, bptc_pkg::REG_CTRL} &&
          s_ff.err != bptc_pkg::ERR_NONE) begin
         nxt_s.ctrl[bptc_pkg::CTL_FEED] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
         s_ff.snap <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign cable.feed_req = s_ff.ctrl[bptc_pkg::CTL_FEED];
   assign print_halt = (s_ff.err != bptc_pkg::ERR_NONE);
   assign irq = |(s_ff.ist & s_ff.imask);
   assign s_axi_awready = !s_ff.aw_got;
   assign s_axi_wready = !s_ff.w_got;
   assign s_axi_bvalid = s_ff.bvalid;
   assign s_axi_bresp = s_ff.bresp;
   assign s_axi_arready = !s_ff.rvalid;
   assign s_axi_rvalid = s_ff.rvalid;
   assign s_axi_rdata = s_ff.rdata;
   assign s_axi_rresp = s_ff.rresp;
endmodule : bptc_engine

// ===== bench/bptc_cable_assertions.sv
/*
 checker for the cable and the elevator pins of the tray end.
 assumes one aclk domain and a synchronous active low aresetn.
*/
`timescale 1ns/1ns
module bptc_cable_assertions #(
   parameter int FEED_CYCLES = bptc_pkg::FEED_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tray_present,
   input wire logic [bptc_pkg::ST_W-1:0] status,
   input wire logic feed_req,
   input wire logic feed_done,
   input wire logic upper_sw_closed,
   input wire logic lower_sw_closed,
   input wire logic door_sw_closed,
   input wire logic paper_out,
   input wire logic motor_up,
   input wire logic motor_down,
   input wire logic feed_motor
);
   logic [31:0] run_ff;
   // cycles the feed motor has been on
   always_ff @(posedge aclk) begin
      if (!aresetn || !feed_motor) begin
         run_ff <= 32'h0;
      end else begin
         run_ff <= run_ff + 32'h1;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_empty;
      paper_out && door_sw_closed && !lower_sw_closed
      ##1 door_sw_closed && !lower_sw_closed;
   endsequence
   sequence s_close;
      $rose(door_sw_closed) && !upper_sw_closed && !paper_out
      ##1 door_sw_closed && !upper_sw_closed && !paper_out;
   endsequence
   a_never_both_dirs: assert property (
      !(motor_up && motor_down)) else $error("elevator driven both ways");
   a_door_halts_motion: assert property (!door_sw_closed |->
      !motor_up && !motor_down) else $error("motion with door open");
   a_top_halts_rise: assert property (
      upper_sw_closed |-> !motor_up) else $error("rise past upper limit");
   a_bottom_halts_fall: assert property (
      lower_sw_closed |-> !motor_down) else $error("fall past lower limit");
   a_power_up_rise: assert property (
      !$past(aresetn) && door_sw_closed && !upper_sw_closed |-> motor_up)
      else $error("no rise after reset");
   a_close_then_rise: assert property (s_close |-> motor_up)
      else $error("no rise after door close");
   a_empty_then_fall: assert property (s_empty |-> motor_down)
      else $error("no descent on empty tray");
   a_feed_run_length: assert property (feed_done |->
      run_ff == 32'(FEED_CYCLES)) else $error("feed length wrong");
   a_feed_has_cause: assert property ($rose(feed_motor) |->
      $past(feed_req) && tray_present) else $error("feed without request");
   a_status_tracks_pins: assert property (
      $past(aresetn) |->
      status[bptc_pkg::ST_AT_TOP] == $past(upper_sw_closed) &&
      status[bptc_pkg::ST_DOOR_OPEN] == !$past(door_sw_closed) &&
      status[bptc_pkg::ST_EMPTY] == $past(paper_out))
      else $error("status word out of step");
endmodule : bptc_cable_assertions

// ===== bench/bptc_tb_top.sv
/*
 testbench joining tray and engine ends, driving switches and axi-lite.
 assumes the design package, cable interface and both ends are compiled.
*/
`timescale 1ns/1ns
module bptc_tb_top;
   localparam logic [4:0] A_CTRL = {1'b0, bptc_pkg::REG_CTRL};
   localparam logic [4:0] A_STAT = {1'b0, bptc_pkg::REG_STATUS};
   localparam logic [4:0] A_ERR = {1'b0, bptc_pkg::REG_ERROR};
   localparam logic [4:0] A_IRQ = {1'b0, bptc_pkg::REG_IRQ_STAT};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic upper_sw_closed = 1'b0, lower_sw_closed = 1'b0;
   logic door_sw_closed = 1'b1, paper_out = 1'b0, lower_key = 1'b0;
   logic motor_up, motor_down, feed_motor, print_halt, irq;
   logic [3:0] jam = 4'h0;
   logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [15:0] codes [5] = '{bptc_pkg::ERR_PREREG, bptc_pkg::ERR_BYP_TRAIL,
      bptc_pkg::ERR_SHINGLE, bptc_pkg::ERR_FUSER_BYP, bptc_pkg::ERR_FUSER_TRAY};
   int bad_count = 0, total_checks = 0, cyc = 0;
   always #5 aclk = ~aclk;
   bptc_cable_if u_bptc_cable_if ();
   bptc_tray #(.FEED_CYCLES(8)) u_bptc_tray (.aclk, .aresetn,
      .cable(u_bptc_cable_if), .upper_sw_closed, .lower_sw_closed,
      .door_sw_closed, .paper_out, .lower_key, .motor_up, .motor_down,
      .feed_motor);
   bptc_engine u_bptc_engine (.aclk, .aresetn, .cable(u_bptc_cable_if),
      .jam, .print_halt, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   bptc_cable_assertions #(.FEED_CYCLES(8)) u_bptc_cable_assertions (.aclk,
      .aresetn, .tray_present(u_bptc_cable_if.tray_present),
      .status(u_bptc_cable_if.status), .feed_req(u_bptc_cable_if.feed_req),
      .feed_done(u_bptc_cable_if.feed_done), .upper_sw_closed,
      .lower_sw_closed, .door_sw_closed, .paper_out, .motor_up, .motor_down,
      .feed_motor);
   task automatic final_report;
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chk_pin(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask : chk_pin
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : wt
   // order: upper, lower, door, paper_out, lower_key
   task automatic pins(input logic [4:0] v);
      @(posedge aclk);
      {upper_sw_closed, lower_sw_closed, door_sw_closed, paper_out,
         lower_key} <= v;
      wt(2);
   endtask : pins
   task automatic axi(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
      logic ta, tw, tr, te;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      te = 1'b0;
      while (!te) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         te = (wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1;
         got = s_axi_rdata;
         resp = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (te) s_axi_bready <= 1'b0;
         if (te) s_axi_rready <= 1'b0;
      end
   endtask : axi
   task automatic rd(input logic [4:0] a, input logic [31:0] e,
      input logic [1:0] er, input string n);
      axi(1'b0, a, 32'h0);
      // let pins settle before callers look at them
      @(negedge aclk);
      chk(n, e, got);
      chk("rresp", {30'h0, er}, {30'h0, resp});
   endtask : rd
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      wt(1);
      chk_pin("motor_up", 1'b1, motor_up);
      pins(5'b10100);
      chk_pin("motor_up", 1'b0, motor_up);
      rd(A_STAT, 32'h0b, bptc_pkg::RESP_OKAY, "status");
      pins(5'b00101);
      chk_pin("motor_down", 1'b1, motor_down);
      pins(5'b00001);
      chk_pin("motor_down", 1'b0, motor_down);
      rd(A_STAT, 32'h23, bptc_pkg::RESP_OKAY, "status");
      pins(5'b00100);
      chk_pin("motor_up", 1'b1, motor_up);
      pins(5'b00110);
      chk_pin("motor_down", 1'b1, motor_down);
      rd(A_ERR, 32'h0703, bptc_pkg::RESP_OKAY, "error");
      chk_pin("print_halt", 1'b1, print_halt);
      chk_pin("irq", 1'b0, irq);
      pins(5'b01100);
      chk_pin("motor_down", 1'b0, motor_down);
      rd(A_ERR, 32'h0, bptc_pkg::RESP_OKAY, "error");
      chk_pin("print_halt", 1'b0, print_halt);
      for (int i = 0; i < 5; i++) begin
         axi(1'b1, A_CTRL, {30'h0, i == 4, 1'b0});
         jam <= (i < 3) ? 4'h1 << i : 4'h8;
         wt(3);
         rd(A_ERR, {16'h0, codes[i]}, bptc_pkg::RESP_OKAY,
            "error");
         @(posedge aclk);
         jam <= 4'h0;
         pins(5'b01000);
         pins(5'b01100);
      end
      rd(A_IRQ, 32'h3, bptc_pkg::RESP_OKAY, "irq_stat");
      rd(A_IRQ, 32'h0, bptc_pkg::RESP_OKAY, "irq_stat");
      axi(1'b1, bptc_pkg::REG_IRQ_MASK_A, 32'h4);
      axi(1'b1, A_CTRL, 32'h1);
      for (int k = 0; k < 10 && feed_motor !== 1'b1; k++) @(negedge aclk);
      chk_pin("feed_motor", 1'b1, feed_motor);
      axi(1'b1, A_CTRL, 32'h1);
      // second request lands mid-feed and must not stretch it
      wt(4);
      chk_pin("feed_motor", 1'b0, feed_motor);
      wt(2);
      chk_pin("irq", 1'b1, irq);
      rd(A_IRQ, 32'h4, bptc_pkg::RESP_OKAY, "irq_stat");
      chk_pin("irq", 1'b0, irq);
      rd(5'h14, 32'h0, bptc_pkg::RESP_SLVERR, "unmapped");
      final_report();
   end
endmodule : bptc_tb_top
